// *** dv/pipe_access_model.sv ***
// Pipeline model presenting timer and counter register accesses
`timescale 1ns/10ps
module pipe_access_model
   import timer_trap_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic issue,
   input wire logic [15:0] word,
   output logic accessValid,
   output logic [1:0] accessLevel,
   output logic accessIs32,
   output logic accessIsRead,
   output access_reg_type accessReg
);
   // ********************
   // Access issue
   // ********************
   // Falling edge launch, so every field is settled at the sampling edge
   always @(negedge clk)
   begin
      accessValid <= issue & reset_n & (word[1:0] != 2'h0);
      accessLevel <= word[2] ? LEVEL_KERNEL : word[4:3];
      accessIs32 <= word[5];
      accessIsRead <= word[6];
      accessReg <= (word[10:7] > 4'h8) ? REG_VIRTUAL_COUNT_VALUE : access_reg_type'(word[10:7]);
   end
endmodule

// *** dv/timer_access_trap_ctrl_tb.sv ***
// Self-checking bench for the timer access trap controls
`timescale 1ns/10ps
module timer_access_trap_ctrl_tb
   import timer_trap_pkg::*;
;
   // ********************
   // Signals
   // ********************
   // Starts low so no false edge at time zero
   logic clk = 1'b0;
   logic reset_n, ctrlWrite, issue, known, bias;
   logic [63:0] ctrlWriteData, ctrlReadData, readNoFeat, readEl3Only;
   logic hostKernelMode, trapGeneralExceptions, nestedVirtOn, nestedVirtLegacyMode, nestedVirtEnhancedMode;
   logic el2Enabled, userVirtCountEnable, userVirtTimerEnable, legacyUserVirtCountEnable, legacyUserVirtTimerEnable;
   logic accessValid, accessIs32, accessIsRead, respValid, respComplete, respHypTrap, respKernelTrap;
   logic [1:0] accessLevel;
   access_reg_type accessReg;
   logic [3:0] respNoFeat, respEl3Only, ctrlModel;
   logic [2:0] expA, expB;
   logic [15:0] word;
   logic [31:0] rnd;
   int err_total, cmp_count;

   timer_access_trap_ctrl timer_access_trap_ctrl_i (.*);
   // Feature absent and EL3-only builds see the same stimulus
   timer_access_trap_ctrl #(.COUNTER_VIRT_FEATURE(1'b0)) timer_access_trap_ctrl_nofeat_i (.*,
      .ctrlReadData(readNoFeat), .respValid(respNoFeat[3]), .respKernelTrap(respNoFeat[2]),
      .respHypTrap(respNoFeat[1]), .respComplete(respNoFeat[0]));
   timer_access_trap_ctrl #(.EL2_PRESENT(1'b0)) timer_access_trap_ctrl_el3only_i (.*,
      .ctrlReadData(readEl3Only), .respValid(respEl3Only[3]), .respKernelTrap(respEl3Only[2]),
      .respHypTrap(respEl3Only[1]), .respComplete(respEl3Only[0]));
   pipe_access_model pipe_access_model_i (.*);

   // ********************
   // Helpers
   // ********************
   function logic [31:0] xorshift(input logic [31:0] s);
      logic [31:0] t;
      begin
         t = s ^ (s << 13);
         t = t ^ (t >> 17);
         xorshift = t ^ (t << 5);
      end
   endfunction

   // Returns kernel, hyp, complete
   function logic [2:0] expect_resp(input logic [3:0] c, input logic el2);
      logic ha, nest, cnt, vt, cs, ts, kern, hyp;
      begin
         ha = hostKernelMode & trapGeneralExceptions;
         nest = !ha & nestedVirtEnhancedMode & !nestedVirtLegacyMode & nestedVirtOn;
         cnt = accessReg == REG_VIRTUAL_COUNT_VALUE;
         vt = accessReg inside {REG_VTIMER_CTRL, REG_VTIMER_COMPARE, REG_VTIMER_COUNTDOWN};
         cs = !userVirtCountEnable | accessIs32 & !legacyUserVirtCountEnable;
         ts = !userVirtTimerEnable | accessIs32 & !legacyUserVirtTimerEnable;
         kern = (accessLevel == LEVEL_USER) & !ha & (cnt & cs | vt & ts);
         hyp = el2 & !kern & ((accessLevel == LEVEL_KERNEL) & nest
            & (c[3] & accessReg inside {REG_VTIMER_CTRL_HOST_ALIAS, REG_VTIMER_COMPARE_HOST_ALIAS}
            | c[2] & accessReg inside {REG_PTIMER_CTRL_HOST_ALIAS, REG_PTIMER_COMPARE_HOST_ALIAS})
            | (accessLevel <= LEVEL_KERNEL) & !ha & (c[1] & cnt & accessIsRead | c[0] & vt));
         expect_resp = {kern, hyp, !kern & !hyp};
      end
   endfunction

   task check(input string what, input logic [63:0] seen, input logic [63:0] want);
      cmp_count++;
      if (seen !== want)
      begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", what, want, seen);
      end
   endtask

   task print_verdict;
      $display("comparisons %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // ********************
   // Reference and checks
   // ********************
   always @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         expA = 3'h0;
         expB = 3'h0;
         known = 1'b0;
      end
      else
      begin
         expA = accessValid ? expect_resp(ctrlModel, el2Enabled) : 3'h0;
         expB = accessValid ? expect_resp(4'h0, 1'b0) : 3'h0;
         if (ctrlWrite)
         begin
            ctrlModel = ctrlWriteData[16:13];
            known = 1'b1;
         end
      end
   end

   always @(negedge clk)
   begin
      check("resp", {respValid, respKernelTrap, respHypTrap, respComplete}, {|expA, expA});
      check("respNoFeat", respNoFeat, {|expB, expB});
      check("respEl3Only", respEl3Only, {|expB, expB});
      check("readNoFeat", readNoFeat, 64'h0);
      if (known === 1'b1)
      begin
         check("read", ctrlReadData, {47'h0, ctrlModel, 13'h0});
         check("readEl3Only", readEl3Only, {47'h0, ctrlModel, 13'h0});
      end
   end

   // ********************
   // Stimulus
   // ********************
   initial
   begin
      forever #5 clk = ~clk;
   end

   initial
   begin
      #200000;
      err_total++;
      print_verdict;
   end

   initial
   begin
      reset_n = 1'b0;
      {ctrlWrite, issue, bias, word} = 19'h0;
      ctrlWriteData = 64'h0;
      {hostKernelMode, trapGeneralExceptions, nestedVirtOn, nestedVirtLegacyMode, nestedVirtEnhancedMode} = 5'h0;
      {el2Enabled, userVirtCountEnable, userVirtTimerEnable, legacyUserVirtCountEnable} = 4'h0;
      legacyUserVirtTimerEnable = 1'b0;
      err_total = 0;
      cmp_count = 0;
      rnd = 32'hB03AC26D;
      repeat (2) @(posedge clk);
      for (int i = 0; i < 3000; i++)
      begin
         @(negedge clk);
         rnd = xorshift(rnd);
         // Every fourth cycle meets the nested condition, else it is too rare
         bias = (i % 4 == 0);
         // Mid-run reset: controls are unknown until written again
         reset_n <= (i != 1500);
         hostKernelMode <= rnd[0];
         trapGeneralExceptions <= rnd[1] & !bias;
         nestedVirtOn <= rnd[2] | bias;
         nestedVirtLegacyMode <= rnd[3] & !bias;
         nestedVirtEnhancedMode <= rnd[4] | bias;
         el2Enabled <= rnd[5] | rnd[6];
         userVirtCountEnable <= rnd[7];
         userVirtTimerEnable <= rnd[8];
         legacyUserVirtCountEnable <= rnd[9];
         legacyUserVirtTimerEnable <= rnd[10];
         ctrlWrite <= (rnd[13:11] == 3'h0) | (i == 0) | (i == 1501);
         // Control bits drawn apart from the write enable bits
         ctrlWriteData <= {rnd, rnd[15:0], rnd[31:16]};
         issue <= known;
         word <= rnd[31:16];
      end
      print_verdict;
   end
endmodule

// *** hw/timer_access_trap_ctrl.sv ***
// Trap controls for lower-level timer and counter accesses
`timescale 1ns/10ps
module timer_access_trap_ctrl
   import timer_trap_pkg::*;
#(
   parameter bit COUNTER_VIRT_FEATURE = 1'b1,
   parameter bit EL2_PRESENT = 1'b1,
   parameter bit EL3_PRESENT = 1'b1
)
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic ctrlWrite,
   input wire logic [CTRL_WIDTH-1:0] ctrlWriteData,
   output logic [CTRL_WIDTH-1:0] ctrlReadData,
   input wire logic hostKernelMode,
   input wire logic trapGeneralExceptions,
   input wire logic nestedVirtOn,
   input wire logic nestedVirtLegacyMode,
   input wire logic nestedVirtEnhancedMode,
   input wire logic el2Enabled,
   input wire logic userVirtCountEnable,
   input wire logic userVirtTimerEnable,
   input wire logic legacyUserVirtCountEnable,
   input wire logic legacyUserVirtTimerEnable,
   input wire logic accessValid,
   input wire logic [1:0] accessLevel,
   input wire logic accessIs32,
   input wire logic accessIsRead,
   input wire access_reg_type accessReg,
   output logic respValid,
   output logic respComplete,
   output logic respHypTrap,
   output logic respKernelTrap
);
   // ****************************************
   // Control bits
   // ****************************************
   logic [3:0] ctrl_reg;
   logic [3:0] ctrl_next;
   logic respValid_reg;
   logic respComplete_reg;
   logic respHypTrap_reg;
   logic respKernelTrap_reg;
   trap_decide_if decideBus ();

   wire [3:0] writeBits = {ctrlWriteData[NESTED_VTIMER_BIT], ctrlWriteData[NESTED_PTIMER_BIT],
      ctrlWriteData[VCOUNT_READ_BIT], ctrlWriteData[VTIMER_ACCESS_BIT]};
   // Bits are reserved zero without the feature
   assign ctrl_next = !COUNTER_VIRT_FEATURE ? TRAP_CTRL_RESET : (ctrlWrite ? writeBits : ctrl_reg);
   // Reset to a fixed value; software must still program it
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         ctrl_reg <= TRAP_CTRL_RESET;
      else
         ctrl_reg <= ctrl_next;
   end

   // Readback shows the stored bits, even where they act as zero
   always_comb
   begin
      ctrlReadData = '0;
      ctrlReadData[NESTED_VTIMER_BIT] = ctrl_reg[FIELD_NESTED_VTIMER];
      ctrlReadData[NESTED_PTIMER_BIT] = ctrl_reg[FIELD_NESTED_PTIMER];
      ctrlReadData[VCOUNT_READ_BIT] = ctrl_reg[FIELD_VCOUNT_READ];
      ctrlReadData[VTIMER_ACCESS_BIT] = ctrl_reg[FIELD_VTIMER_ACCESS];
   end

   // ****************************************
   // Decision
   // ****************************************
   // EL3 without EL2 forces every control to zero
   wire el3Only = EL3_PRESENT && !EL2_PRESENT;
   // No dependence on the enhanced virtualization enable
   assign decideBus.ctrlEff = el3Only ? TRAP_CTRL_RESET : ctrl_reg;
   assign decideBus.hostKernelMode = hostKernelMode;
   assign decideBus.trapGeneralExceptions = trapGeneralExceptions;
   assign decideBus.nestedVirtOn = nestedVirtOn;
   assign decideBus.nestedVirtLegacyMode = nestedVirtLegacyMode;
   assign decideBus.nestedVirtEnhancedMode = nestedVirtEnhancedMode;
   assign decideBus.el2Enabled = el2Enabled & EL2_PRESENT;
   assign decideBus.accessLevel = accessLevel;
   assign decideBus.accessIs32 = accessIs32;
   assign decideBus.accessIsRead = accessIsRead;
   assign decideBus.accessReg = accessReg;
   assign decideBus.userVirtCountEnable = userVirtCountEnable;
   assign decideBus.userVirtTimerEnable = userVirtTimerEnable;
   assign decideBus.legacyUserVirtCountEnable = legacyUserVirtCountEnable;
   assign decideBus.legacyUserVirtTimerEnable = legacyUserVirtTimerEnable;

   trap_decider decider (
      .bus(decideBus)
   );

   // ****************************************
   // Response
   // ****************************************
   // A trapped access does not complete
   wire completeNow = accessValid & ~decideBus.hypTrap & ~decideBus.kernelTrap;
   // Kernel trap masks the hypervisor trap
   wire hypNow = accessValid & decideBus.hypTrap & ~decideBus.kernelTrap;
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         respValid_reg <= 1'b0;
         respComplete_reg <= 1'b0;
         respHypTrap_reg <= 1'b0;
         respKernelTrap_reg <= 1'b0;
      end
      else
      begin
         respValid_reg <= accessValid;
         respComplete_reg <= completeNow;
         respHypTrap_reg <= hypNow;
         respKernelTrap_reg <= accessValid & decideBus.kernelTrap;
      end
   end
   assign respValid = respValid_reg;
   assign respComplete = respComplete_reg;
   assign respHypTrap = respHypTrap_reg;
   assign respKernelTrap = respKernelTrap_reg;

   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   wire hostAllIn = hostKernelMode & trapGeneralExceptions;
   wire nestedCond = ~hostAllIn & nestedVirtEnhancedMode & ~nestedVirtLegacyMode & nestedVirtOn;

   resp_latency_a: assert property (accessValid |=> respValid)
      else $error("response missing one cycle after access");

   resp_idle_a: assert property (!accessValid |=> !respValid && !respComplete && !respHypTrap && !respKernelTrap)
      else $error("response without an access");

   // ****************************************
   // Trap decision checks
   // ****************************************
   zero_ctrl_quiet_a: assert property (accessValid && decideBus.ctrlEff == 4'h0 |=> !respHypTrap)
      else $error("hypervisor trap with all controls clear");

   nested_vtimer_trap_a: assert property (accessValid && decideBus.ctrlEff[FIELD_NESTED_VTIMER]
      && decideBus.el2Enabled && accessLevel == LEVEL_KERNEL && accessReg == REG_VTIMER_CTRL_HOST_ALIAS
      && nestedCond |=> respHypTrap && !respComplete)
      else $error("nested virtual alias access not trapped");

   nested_ptimer_trap_a: assert property (accessValid && decideBus.ctrlEff[FIELD_NESTED_PTIMER]
      && decideBus.el2Enabled && accessLevel == LEVEL_KERNEL && accessReg == REG_PTIMER_COMPARE_HOST_ALIAS
      && nestedCond |=> respHypTrap && !respComplete)
      else $error("nested physical alias access not trapped");

   nested_ptimer_quiet_a: assert property (accessValid && (accessReg == REG_PTIMER_CTRL_HOST_ALIAS
      || accessReg == REG_PTIMER_COMPARE_HOST_ALIAS) && !nestedCond |=> !respHypTrap)
      else $error("physical alias trapped outside nested condition");

   alias_user_quiet_a: assert property (accessValid && accessLevel != LEVEL_KERNEL && (accessReg inside
      {REG_VTIMER_CTRL_HOST_ALIAS, REG_VTIMER_COMPARE_HOST_ALIAS, REG_PTIMER_CTRL_HOST_ALIAS,
      REG_PTIMER_COMPARE_HOST_ALIAS}) |=> !respHypTrap)
      else $error("host alias trapped outside kernel level");

   host_mode_quiet_a: assert property (accessValid && hostAllIn |=> !respHypTrap && !respKernelTrap)
      else $error("trap taken in host kernel mode");

   vcount_trap_a: assert property (accessValid && decideBus.ctrlEff[FIELD_VCOUNT_READ]
      && decideBus.el2Enabled && accessLevel == LEVEL_KERNEL && accessReg == REG_VIRTUAL_COUNT_VALUE
      && accessIsRead && !hostAllIn |=> respHypTrap)
      else $error("virtual count read not trapped");

   vcount_write_quiet_a: assert property (accessValid && accessLevel == LEVEL_KERNEL
      && accessReg == REG_VIRTUAL_COUNT_VALUE && !accessIsRead |=> !respHypTrap && respComplete)
      else $error("virtual count write trapped");

   kernel_count_first_a: assert property (accessValid && accessLevel == LEVEL_USER && !hostAllIn
      && accessReg == REG_VIRTUAL_COUNT_VALUE && !userVirtCountEnable |=> respKernelTrap && !respHypTrap)
      else $error("kernel count trap not taken first");

   vtimer_trap_a: assert property (accessValid && decideBus.ctrlEff[FIELD_VTIMER_ACCESS]
      && decideBus.el2Enabled && accessLevel == LEVEL_USER && !hostAllIn && accessReg == REG_VTIMER_COUNTDOWN
      && userVirtTimerEnable && (!accessIs32 || legacyUserVirtTimerEnable) |=> respHypTrap)
      else $error("virtual timer access not trapped");

   kernel_timer_first_a: assert property (accessValid && accessLevel == LEVEL_USER && !hostAllIn
      && accessReg == REG_VTIMER_CTRL && accessIs32 && !legacyUserVirtTimerEnable |=> respKernelTrap)
      else $error("kernel timer trap not taken first");

   kernel_first_a: assert property (respKernelTrap |-> !respHypTrap && !respComplete)
      else $error("kernel trap and hypervisor trap together");

   el2_off_quiet_a: assert property (accessValid && !decideBus.el2Enabled |=> !respHypTrap)
      else $error("hypervisor trap with EL2 disabled");

   high_level_quiet_a: assert property (accessValid && accessLevel > LEVEL_KERNEL |=> respComplete)
      else $error("higher level access not completed");

   // ****************************************
   // Control bit checks
   // ****************************************
   el3_only_a: assert property (el3Only |-> decideBus.ctrlEff == 4'h0)
      else $error("controls active with EL3 only");

   el3_only_quiet_a: assert property (el3Only && accessValid |=> !respHypTrap)
      else $error("hypervisor trap with EL3 only");

   readback_a: assert property (ctrlWrite && COUNTER_VIRT_FEATURE |=>
      ctrlReadData[NESTED_VTIMER_BIT] == $past(ctrlWriteData[NESTED_VTIMER_BIT])
      && ctrlReadData[NESTED_PTIMER_BIT] == $past(ctrlWriteData[NESTED_PTIMER_BIT])
      && ctrlReadData[VCOUNT_READ_BIT] == $past(ctrlWriteData[VCOUNT_READ_BIT])
      && ctrlReadData[VTIMER_ACCESS_BIT] == $past(ctrlWriteData[VTIMER_ACCESS_BIT]))
      else $error("control readback mismatch");

   readback_hold_a: assert property (!ctrlWrite |=> $stable(ctrlReadData))
      else $error("control bits changed without a write");

   complete_excl_a: assert property (respValid |-> respComplete == !(respHypTrap || respKernelTrap))
      else $error("trapped access completed");

   absent_zero_a: assert property (!COUNTER_VIRT_FEATURE |-> ctrlReadData == '0)
      else $error("reserved bits read nonzero");
endmodule

// *** hw/timer_trap_pkg.sv ***
// Constants and types for the timer access trap controls
package timer_trap_pkg;
   localparam int CTRL_WIDTH = 64;
   localparam int NESTED_VTIMER_BIT = 16;
   localparam int NESTED_PTIMER_BIT = 15;
   localparam int VCOUNT_READ_BIT = 14;
   localparam int VTIMER_ACCESS_BIT = 13;
   localparam int FIELD_NESTED_VTIMER = 3;
   localparam int FIELD_NESTED_PTIMER = 2;
   localparam int FIELD_VCOUNT_READ = 1;
   localparam int FIELD_VTIMER_ACCESS = 0;
   localparam logic [3:0] TRAP_CTRL_RESET = 4'h0;
   localparam logic [1:0] LEVEL_USER = 2'h0;
   localparam logic [1:0] LEVEL_KERNEL = 2'h1;

   typedef enum logic [3:0] {
      REG_OTHER = 4'b0000,
      REG_VTIMER_CTRL_HOST_ALIAS = 4'b0001,
      REG_VTIMER_COMPARE_HOST_ALIAS = 4'b0010,
      REG_PTIMER_CTRL_HOST_ALIAS = 4'b0011,
      REG_PTIMER_COMPARE_HOST_ALIAS = 4'b0100,
      REG_VIRTUAL_COUNT_VALUE = 4'b0101,
      REG_VTIMER_CTRL = 4'b0110,
      REG_VTIMER_COMPARE = 4'b0111,
      REG_VTIMER_COUNTDOWN = 4'b1000
   } access_reg_type;
endpackage

// *** hw/trap_decide_if.sv ***
// Interface between the control register holder and the trap decider
`timescale 1ns/10ps
interface trap_decide_if;
   import timer_trap_pkg::*;
   logic [3:0] ctrlEff;
   logic hostKernelMode;
   logic trapGeneralExceptions;
   logic nestedVirtOn;
   logic nestedVirtLegacyMode;
   logic nestedVirtEnhancedMode;
   logic el2Enabled;
   logic [1:0] accessLevel;
   logic accessIs32;
   logic accessIsRead;
   access_reg_type accessReg;
   logic userVirtCountEnable;
   logic userVirtTimerEnable;
   logic legacyUserVirtCountEnable;
   logic legacyUserVirtTimerEnable;
   logic hypTrap;
   logic kernelTrap;
   modport requester (
      output ctrlEff, hostKernelMode, trapGeneralExceptions, nestedVirtOn, nestedVirtLegacyMode,
      nestedVirtEnhancedMode, el2Enabled, accessLevel, accessIs32, accessIsRead, accessReg,
      userVirtCountEnable, userVirtTimerEnable, legacyUserVirtCountEnable, legacyUserVirtTimerEnable,
      input hypTrap, kernelTrap
   );
   modport decider (
      input ctrlEff, hostKernelMode, trapGeneralExceptions, nestedVirtOn, nestedVirtLegacyMode,
      nestedVirtEnhancedMode, el2Enabled, accessLevel, accessIs32, accessIsRead, accessReg,
      userVirtCountEnable, userVirtTimerEnable, legacyUserVirtCountEnable, legacyUserVirtTimerEnable,
      output hypTrap, kernelTrap
   );
endinterface

// *** hw/trap_decider.sv ***
// Combinational trap decision for one system register access
`timescale 1ns/10ps
module trap_decider
   import timer_trap_pkg::*;
(
   trap_decide_if.decider bus
);
   wire hostAll = bus.hostKernelMode & bus.trapGeneralExceptions;
   wire lowLevel = (bus.accessLevel == LEVEL_USER) | (bus.accessLevel == LEVEL_KERNEL);
   wire fromKernel = bus.accessLevel == LEVEL_KERNEL;
   wire fromUser = bus.accessLevel == LEVEL_USER;
   wire isValias = (bus.accessReg == REG_VTIMER_CTRL_HOST_ALIAS) | (bus.accessReg == REG_VTIMER_COMPARE_HOST_ALIAS);
   wire isPalias = (bus.accessReg == REG_PTIMER_CTRL_HOST_ALIAS) | (bus.accessReg == REG_PTIMER_COMPARE_HOST_ALIAS);
   wire isVcount = bus.accessReg == REG_VIRTUAL_COUNT_VALUE;
   wire isVtimer = (bus.accessReg == REG_VTIMER_CTRL) | (bus.accessReg == REG_VTIMER_COMPARE)
      | (bus.accessReg == REG_VTIMER_COUNTDOWN);
   wire nestedOk = ~hostAll & bus.nestedVirtEnhancedMode & ~bus.nestedVirtLegacyMode & bus.nestedVirtOn;
   wire nestedVtrap = bus.ctrlEff[FIELD_NESTED_VTIMER] & bus.el2Enabled & fromKernel & isValias & nestedOk;
   wire nestedPtrap = bus.ctrlEff[FIELD_NESTED_PTIMER] & bus.el2Enabled & fromKernel & isPalias & nestedOk;
   // Kernel enables only police user level outside host mode
   wire countKernel = fromUser & ~hostAll & isVcount
      & (~bus.userVirtCountEnable | (bus.accessIs32 & ~bus.legacyUserVirtCountEnable));
   wire timerKernel = fromUser & ~hostAll & isVtimer
      & (~bus.userVirtTimerEnable | (bus.accessIs32 & ~bus.legacyUserVirtTimerEnable));
   wire vcountTrap = bus.ctrlEff[FIELD_VCOUNT_READ] & bus.el2Enabled & lowLevel & ~hostAll
      & isVcount & bus.accessIsRead & ~countKernel;
   wire vtimerTrap = bus.ctrlEff[FIELD_VTIMER_ACCESS] & bus.el2Enabled & lowLevel & ~hostAll
      & isVtimer & ~timerKernel;
   assign bus.kernelTrap = countKernel | timerKernel;
   assign bus.hypTrap = nestedVtrap | nestedPtrap | vcountTrap | vtimerTrap;
endmodule
